// ===== core/tmw_pkg.sv
/*
  tmw_pkg: constants, register map and state types of the timer waveform block.
  Assumes one 40 MHz clock, synchronous active-high reset, AHB-Lite register access.
*/
// Function
// RULE1 - force a drives level a when no modes
// RULE2 - force b drives level b on output b
// RULE3 - forcing raises no flag; matches still do
// RULE4 - capture keeps working under force and single pulse
// RULE5 - trigger reloads fffc, level b after four
// RULE6 - match a ends pulse with level a
// RULE7 - single pulse never sets flag a
// RULE8 - trigger sets capture flag a, capture fffc
// RULE9 - both modes: single pulse if force a
// RULE10 - compare a fffb gives ffff long pulse
// RULE11 - retrigger or count write before match restarts
// RULE12 - pwm: match a level a, match b reload
// RULE13 - pwm never sets flag a, flag b each period
// RULE14 - compare a beyond b gives no waveform
// RULE15 - equal compares give square wave
// RULE16 - both fffc: counter stuck, output toggles
// RULE17 - pwm with force b drives level b
// RULE18 - width measure: period to a, width to b
// RULE19 - first capture a interrupt suppressed
// RULE20 - software sets edges inverse, then enable
// RULE21 - registers accessed only as whole words
// RULE22 - capture registers read only, hold latched count
// RULE23 - everything acts on timer tick; here captures, triggers and the level b delay act on every clock
package tmw_pkg;
  localparam logic [7:0] tmw_off_capture_a = 8'h00;
  localparam logic [7:0] tmw_off_capture_b = 8'h04;
  localparam logic [7:0] tmw_off_compare_a = 8'h08;
  localparam logic [7:0] tmw_off_compare_b = 8'h0C;
  localparam logic [7:0] tmw_off_count = 8'h10;
  localparam logic [7:0] tmw_off_control1 = 8'h14;
  localparam logic [7:0] tmw_off_control2 = 8'h18;
  localparam logic [7:0] tmw_off_status = 8'h1C;
  localparam logic [15:0] tmw_count_reload = 16'hFFFC;
  localparam logic [15:0] tmw_count_zero = 16'h0000;
  localparam logic [15:0] tmw_count_max = 16'hFFFF;
  localparam logic [15:0] tmw_compare_reset = 16'h8000;
  localparam logic [15:0] tmw_ctrl_reset = 16'h0000;
  localparam logic [2:0] tmw_level_delay = 3'h4;
  // control 1 fields
  localparam int tmw_b_enable = 15;
  localparam int tmw_b_width_measure = 14;
  localparam int tmw_b_force_b = 11;
  localparam int tmw_b_force_a = 10;
  localparam int tmw_b_level_b = 9;
  localparam int tmw_b_level_a = 8;
  localparam int tmw_b_out_b_en = 7;
  localparam int tmw_b_out_a_en = 6;
  localparam int tmw_b_single_pulse = 5;
  localparam int tmw_b_pwm = 4;
  localparam int tmw_b_edge_b = 3;
  localparam int tmw_b_edge_a = 2;
  localparam int tmw_b_ext_edge = 1;
  localparam int tmw_b_ext_en = 0;
  localparam logic [15:0] tmw_ctrl1_mask = 16'hCFFF;
  // control 2 fields: prescale in low byte, enables above
  localparam int tmw_b_cap_a_ie = 15;
  localparam int tmw_b_cmp_a_ie = 14;
  localparam int tmw_b_ovf_ie = 13;
  localparam int tmw_b_cap_b_ie = 12;
  localparam int tmw_b_cmp_b_ie = 11;
  localparam logic [15:0] tmw_ctrl2_mask = 16'hF8FF;
  // status fields, write zero clears
  localparam int tmw_s_cap_a = 15;
  localparam int tmw_s_cmp_a = 14;
  localparam int tmw_s_ovf = 13;
  localparam int tmw_s_cap_b = 12;
  localparam int tmw_s_cmp_b = 11;
  localparam logic [15:0] tmw_status_mask = 16'hF800;
  localparam logic [1:0] tmw_htrans_nonseq = 2'h2;
  localparam logic [2:0] tmw_hsize_word = 3'h2;

  typedef enum logic [1:0] {tmw_mode_plain, tmw_mode_single, tmw_mode_pwm, tmw_mode_measure} tmw_mode_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] capture_a;
    logic [15:0] capture_b;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic [15:0] status;
    logic [7:0] prescale_cnt;
    logic ext_prev;
    logic cap_a_prev;
    logic cap_b_prev;
    logic out_a;
    logic out_b;
    logic [2:0] level_wait;
    logic pulse_active;
    logic pwm_square_phase;
    logic measure_first;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } tmw_state_t;

  typedef struct packed {
    logic sel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } tmw_ahb_in_t;
endpackage : tmw_pkg

// ===== core/tmw_timer.sv
/*
  tmw_timer: 16-bit timer with forced compare, single pulse, pwm and width measure modes,
  register file on an AHB-Lite slave. Assumes all pins synchronous to clock.
*/
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module tmw_timer (
  input wire logic clock,
  input wire logic rst,
  input wire tmw_pkg::tmw_ahb_in_t ahb_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic ext_clock_in,
  output logic compare_out_a,
  output logic compare_out_b,
  output logic irq
);
  tmw_pkg::tmw_state_t s_reg;
  tmw_pkg::tmw_state_t s_next;
  tmw_pkg::tmw_mode_t mode;
  logic tick;
  logic edge_a;
  logic edge_b;
  logic match_a;
  logic match_b;
  logic wr_en;
  logic [15:0] wdata;
  logic count_write;
  logic [15:0] ord_a;
  logic [15:0] ord_b;

  // mode resolution, single pulse wins over pwm only when force a is set
  always_comb begin
    if (s_reg.ctrl1[tmw_pkg::tmw_b_width_measure]) begin
      mode = tmw_pkg::tmw_mode_measure;
    end else if (s_reg.ctrl1[tmw_pkg::tmw_b_single_pulse] &&
                 (!s_reg.ctrl1[tmw_pkg::tmw_b_pwm] || s_reg.ctrl1[tmw_pkg::tmw_b_force_a])) begin
      mode = tmw_pkg::tmw_mode_single; // RULE9
    end else if (s_reg.ctrl1[tmw_pkg::tmw_b_pwm]) begin
      mode = tmw_pkg::tmw_mode_pwm; // RULE9
    end else begin
      mode = tmw_pkg::tmw_mode_plain;
    end
  end

  // data-phase write strobe, taken as a whole word whatever the transfer size
  assign wr_en = s_reg.ap_valid && s_reg.ap_write;
  assign wdata = ahb_in.hwdata[15:0];
  assign count_write = wr_en && (s_reg.ap_addr == tmw_pkg::tmw_off_count);

  // input edges by selected polarity
  assign edge_a = (capture_in_a != s_reg.cap_a_prev) &&
                  (capture_in_a == s_reg.ctrl1[tmw_pkg::tmw_b_edge_a]);
  assign edge_b = (capture_in_b != s_reg.cap_b_prev) &&
                  (capture_in_b == s_reg.ctrl1[tmw_pkg::tmw_b_edge_b]);

  // timer tick: prescaler or external edge, gated by enable
  always_comb begin
    if (!s_reg.ctrl1[tmw_pkg::tmw_b_enable]) begin
      tick = 1'b0;
    end else if (s_reg.ctrl1[tmw_pkg::tmw_b_ext_en]) begin
      tick = (ext_clock_in != s_reg.ext_prev) && (ext_clock_in == s_reg.ctrl1[tmw_pkg::tmw_b_ext_edge]);
    end else begin
      tick = (s_reg.prescale_cnt == s_reg.ctrl2[7:0]);
    end
  end

  assign match_a = tick && (s_reg.count == s_reg.compare_a);
  assign match_b = tick && (s_reg.count == s_reg.compare_b);

  // rollover order: fffc..ffff come before 0000
  assign ord_a = s_reg.compare_a - tmw_pkg::tmw_count_reload;
  assign ord_b = s_reg.compare_b - tmw_pkg::tmw_count_reload;

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.ext_prev = ext_clock_in;
    s_next.cap_a_prev = capture_in_a;
    s_next.cap_b_prev = capture_in_b;
    s_next.ap_valid = 1'b0;
    // prescaler
    if (!s_reg.ctrl1[tmw_pkg::tmw_b_enable] || s_reg.ctrl1[tmw_pkg::tmw_b_ext_en] ||
        s_reg.prescale_cnt == s_reg.ctrl2[7:0]) begin
      s_next.prescale_cnt = 8'h00;
    end else begin
      s_next.prescale_cnt = s_reg.prescale_cnt + 8'h01;
    end
    // counter advance
    if (tick) begin
      s_next.count = s_reg.count + 16'h0001; // RULE23
      if (s_reg.count == tmw_pkg::tmw_count_max) begin
        s_next.status[tmw_pkg::tmw_s_ovf] = 1'b1;
      end
    end
    // compare flags; forcing alone never sets them
    if (match_a && mode != tmw_pkg::tmw_mode_single && mode != tmw_pkg::tmw_mode_pwm) begin
      s_next.status[tmw_pkg::tmw_s_cmp_a] = 1'b1; // RULE3 RULE7 RULE13
    end
    if (match_b) begin
      s_next.status[tmw_pkg::tmw_s_cmp_b] = 1'b1; // RULE3 RULE7 RULE13
    end
    // plain compare outputs
    if (mode == tmw_pkg::tmw_mode_plain || mode == tmw_pkg::tmw_mode_measure) begin
      if (match_a) begin
        s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_a];
      end
      if (s_reg.ctrl1[tmw_pkg::tmw_b_force_a]) begin
        s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_a]; // RULE1
      end
    end
    if (match_b) begin
      s_next.out_b = s_reg.ctrl1[tmw_pkg::tmw_b_level_b];
    end
    if (s_reg.ctrl1[tmw_pkg::tmw_b_force_b]) begin
      s_next.out_b = s_reg.ctrl1[tmw_pkg::tmw_b_level_b]; // RULE2 RULE4 RULE17
    end
    // capture b works in every mode
    if (edge_b) begin
      s_next.capture_b = s_reg.count; // RULE4 RULE18 RULE22
      s_next.status[tmw_pkg::tmw_s_cap_b] = 1'b1;
    end
    case (mode)
      tmw_pkg::tmw_mode_single: begin
        // pulse starts four clocks after trigger
        if (s_reg.level_wait != 3'h0) begin
          s_next.level_wait = s_reg.level_wait - 3'h1;
          if (s_reg.level_wait == 3'h1) begin
            s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_b]; // RULE5
          end
        end
        if (match_a && s_reg.pulse_active) begin
          s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_a]; // RULE6 RULE10
          s_next.pulse_active = 1'b0;
        end
        if (edge_a || (count_write && s_reg.pulse_active)) begin
          s_next.count = tmw_pkg::tmw_count_reload; // RULE5 RULE11
          s_next.pulse_active = 1'b1;
          if (edge_a) begin
            s_next.level_wait = tmw_pkg::tmw_level_delay; // RULE5
          end
        end
        if (edge_a) begin
          s_next.capture_a = tmw_pkg::tmw_count_reload; // RULE8
          s_next.status[tmw_pkg::tmw_s_cap_a] = 1'b1; // RULE8 RULE4
        end
      end
      tmw_pkg::tmw_mode_pwm: begin
        if (ord_a <= ord_b) begin // RULE14
          if (match_a && match_b) begin
            // equal compares: alternate levels each period
            s_next.out_a = s_reg.pwm_square_phase ? s_reg.ctrl1[tmw_pkg::tmw_b_level_b] :
                                                    s_reg.ctrl1[tmw_pkg::tmw_b_level_a]; // RULE15 RULE16
            s_next.pwm_square_phase = !s_reg.pwm_square_phase;
          end else if (match_b) begin
            s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_b]; // RULE12
          end else if (match_a) begin
            s_next.out_a = s_reg.ctrl1[tmw_pkg::tmw_b_level_a]; // RULE12
          end
        end
        if (match_b) begin
          s_next.count = tmw_pkg::tmw_count_reload; // RULE12 RULE16
        end
        if (edge_a) begin
          s_next.capture_a = s_reg.count;
          s_next.status[tmw_pkg::tmw_s_cap_a] = 1'b1;
        end
      end
      tmw_pkg::tmw_mode_measure: begin
        if (edge_a) begin
          s_next.capture_a = s_reg.count; // RULE18
          s_next.count = tmw_pkg::tmw_count_zero; // RULE18
          s_next.measure_first = 1'b0;
          s_next.status[tmw_pkg::tmw_s_cap_a] = !s_reg.measure_first || s_reg.status[tmw_pkg::tmw_s_cap_a]; // RULE19
        end
        if ((capture_in_a != s_reg.cap_a_prev) && !edge_a) begin
          s_next.capture_b = s_reg.count; // RULE18
        end
      end
      default: begin
        if (edge_a) begin
          s_next.capture_a = s_reg.count; // RULE4 RULE22
          s_next.status[tmw_pkg::tmw_s_cap_a] = 1'b1;
        end
      end
    endcase
    if (mode != tmw_pkg::tmw_mode_measure) begin
      s_next.measure_first = 1'b1;
    end
    if (mode != tmw_pkg::tmw_mode_single) begin
      s_next.level_wait = 3'h0;
      s_next.pulse_active = 1'b0;
    end
    if (mode != tmw_pkg::tmw_mode_pwm) begin
      s_next.pwm_square_phase = 1'b0;
    end
    // register writes, data phase
    if (wr_en) begin
      case (s_reg.ap_addr)
        tmw_pkg::tmw_off_compare_a: s_next.compare_a = wdata;
        tmw_pkg::tmw_off_compare_b: s_next.compare_b = wdata;
        tmw_pkg::tmw_off_count: begin
          if (mode != tmw_pkg::tmw_mode_single || s_reg.pulse_active) begin
            s_next.count = tmw_pkg::tmw_count_reload; // RULE11
          end
        end
        tmw_pkg::tmw_off_control1: s_next.ctrl1 = wdata & tmw_pkg::tmw_ctrl1_mask;
        tmw_pkg::tmw_off_control2: s_next.ctrl2 = wdata & tmw_pkg::tmw_ctrl2_mask;
        // write zero clears, a flag newly set in the same cycle survives; one already set is cleared
        tmw_pkg::tmw_off_status: s_next.status = s_next.status & (wdata | ~(s_reg.status & tmw_pkg::tmw_status_mask));
        default: s_next.ap_valid = 1'b0;
      endcase
    end
    // address phase capture
    if (ahb_in.sel && ahb_in.hready && ahb_in.htrans == tmw_pkg::tmw_htrans_nonseq) begin
      s_next.ap_valid = 1'b1;
      s_next.ap_write = ahb_in.hwrite;
      s_next.ap_addr = ahb_in.haddr[7:0];
      case (ahb_in.haddr[7:0])
        tmw_pkg::tmw_off_capture_a: s_next.rdata = {16'h0000, s_reg.capture_a}; // RULE22
        tmw_pkg::tmw_off_capture_b: s_next.rdata = {16'h0000, s_reg.capture_b}; // RULE22
        tmw_pkg::tmw_off_compare_a: s_next.rdata = {16'h0000, s_reg.compare_a};
        tmw_pkg::tmw_off_compare_b: s_next.rdata = {16'h0000, s_reg.compare_b};
        tmw_pkg::tmw_off_count: s_next.rdata = {16'h0000, s_reg.count};
        tmw_pkg::tmw_off_control1: s_next.rdata = {16'h0000, s_reg.ctrl1};
        tmw_pkg::tmw_off_control2: s_next.rdata = {16'h0000, s_reg.ctrl2};
        tmw_pkg::tmw_off_status: s_next.rdata = {16'h0000, s_next.status};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.count <= tmw_pkg::tmw_count_reload;
      s_reg.compare_a <= tmw_pkg::tmw_compare_reset;
      s_reg.compare_b <= tmw_pkg::tmw_compare_reset;
      s_reg.ctrl1 <= tmw_pkg::tmw_ctrl_reset;
      s_reg.ctrl2 <= tmw_pkg::tmw_ctrl_reset;
      s_reg.measure_first <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs; pins low unless their output enable is set
  assign compare_out_a = s_reg.out_a && s_reg.ctrl1[tmw_pkg::tmw_b_out_a_en];
  assign compare_out_b = s_reg.out_b && s_reg.ctrl1[tmw_pkg::tmw_b_out_b_en]; // RULE17
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1; // RULE21
  assign hresp = 1'b0;
  assign irq = (s_reg.status[tmw_pkg::tmw_s_cap_a] && s_reg.ctrl2[tmw_pkg::tmw_b_cap_a_ie]) ||
               (s_reg.status[tmw_pkg::tmw_s_cmp_a] && s_reg.ctrl2[tmw_pkg::tmw_b_cmp_a_ie]) ||
               (s_reg.status[tmw_pkg::tmw_s_ovf] && s_reg.ctrl2[tmw_pkg::tmw_b_ovf_ie]) ||
               (s_reg.status[tmw_pkg::tmw_s_cap_b] && s_reg.ctrl2[tmw_pkg::tmw_b_cap_b_ie]) ||
               (s_reg.status[tmw_pkg::tmw_s_cmp_b] && s_reg.ctrl2[tmw_pkg::tmw_b_cmp_b_ie]);
endmodule : tmw_timer

// ===== verification/tmw_chk.sv
/*
  tmw_chk: port assertions for tmw_timer, bound below.
  assumes hready is tied to hreadyout and writes are whole words.
*/
`timescale 1ns/1ps
module tmw_chk (
  input wire logic clock,
  input wire logic rst,
  input wire tmw_pkg::tmw_ahb_in_t ahb_in,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic capture_in_a,
  input wire logic compare_out_a,
  input wire logic compare_out_b,
  input wire logic irq
);
  logic wr_reg;
  logic [7:0] ad_reg;
  logic [15:0] c1_reg, c2_reg, ca_reg;
  logic sgl;
  // shadow copies of control and compare a writes
  always_ff @(posedge clock) begin
    ad_reg <= ahb_in.haddr[7:0];
    if (rst) begin
      wr_reg <= 1'b0;
      c1_reg <= 16'h0000;
      c2_reg <= 16'h0000;
      ca_reg <= 16'h8000;
    end else begin
      wr_reg <= ahb_in.sel && ahb_in.hready && ahb_in.htrans == 2'h2 && ahb_in.hwrite;
      if (wr_reg && ad_reg == 8'h14) c1_reg <= ahb_in.hwdata[15:0] & 16'hCFFF;
      if (wr_reg && ad_reg == 8'h18) c2_reg <= ahb_in.hwdata[15:0] & 16'hF8FF;
      if (wr_reg && ad_reg == 8'h08) ca_reg <= ahb_in.hwdata[15:0];
    end
  end
  // single pulse wins over pwm only with force a
  assign sgl = !c1_reg[14] && c1_reg[5] && (!c1_reg[4] || c1_reg[10]);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_bus;
    hreadyout && !hresp && hrdata[31:16] == 16'h0000;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer not zero wait okay");
  property p_unmapped;
    ahb_in.sel && ahb_in.hready && ahb_in.htrans == 2'h2 && !ahb_in.hwrite && ahb_in.haddr[7:0] >= 8'h20
      |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_force_a;
    (c1_reg[10] && !c1_reg[4] && !c1_reg[5] && c1_reg[6] && $stable(c1_reg)) [*3] |-> compare_out_a == c1_reg[8];
  endproperty
  a_force_a: assert property (p_force_a) else $error("forced level a missing");
  property p_force_b;
    (c1_reg[11] && c1_reg[7] && $stable(c1_reg)) [*3] |-> compare_out_b == c1_reg[9];
  endproperty
  a_force_b: assert property (p_force_b) else $error("forced level b missing");
  property p_off_b;
    (!c1_reg[7] && $stable(c1_reg)) [*2] |-> !compare_out_b;
  endproperty
  a_off_b: assert property (p_off_b) else $error("output b driven while disabled");
  sequence s_trig;
    sgl && c1_reg[6] && ca_reg > 16'h0008 && ca_reg < 16'hFF00 && capture_in_a != $past(capture_in_a)
      && capture_in_a == c1_reg[2];
  endsequence
  property p_pulse;
    s_trig ##1 $stable(c1_reg) [*5] |-> ##[0:1] compare_out_a == c1_reg[9];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse level late");
  property p_irq_src;
    $rose(irq) |-> c2_reg[15:11] != 5'h00;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without enable");
  property p_no_flag_a;
    $stable(c1_reg) && $stable(c2_reg) && !c1_reg[14] && (c1_reg[4] || c1_reg[5]) && c2_reg[15:11] == 5'h08
      |-> !$rose(irq);
  endproperty
  a_no_flag_a: assert property (p_no_flag_a) else $error("compare a flag set in mode");
endmodule : tmw_chk
bind tmw_timer tmw_chk u_chk (.clock(clock), .rst(rst), .ahb_in(ahb_in), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .capture_in_a(capture_in_a), .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b), .irq(irq));

// ===== verification/tmw_pins.sv
/*
  tmw_pins: far side model driving capture pins and a slow external clock.
  assumes the bench calls pulse from one process at a time.
*/
`timescale 1ns/1ps
module tmw_pins (
  input wire logic clock,
  output logic capture_in_a,
  output logic capture_in_b,
  output logic ext_clock_in
);
  logic [1:0] div_reg = 2'h0;
  initial begin
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
    ext_clock_in = 1'b0;
  end
  // external clock at a quarter of the bus clock
  always @(posedge clock) begin
    div_reg <= div_reg + 2'h1;
    ext_clock_in <= div_reg[1];
  end
  // one high pulse on a capture pin, then low
  task automatic pulse(input int ch, input int hi, input int lo);
    @(posedge clock);
    if (ch == 0) capture_in_a <= 1'b1;
    else capture_in_b <= 1'b1;
    repeat (hi) @(posedge clock);
    if (ch == 0) capture_in_a <= 1'b0;
    else capture_in_b <= 1'b0;
    repeat (lo - 1) @(posedge clock);
  endtask : pulse
endmodule : tmw_pins

// ===== verification/tb_top.sv
/*
  tb_top: register and pin scenarios for tmw_timer.
  assumes a zero wait slave and the tmw_pins model on the pins.
*/
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tmw_pkg::tmw_ahb_in_t m = '0;
  tmw_pkg::tmw_ahb_in_t bus;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cia, cib, eck, oa, ob, irq;
  logic [15:0] rd, sv;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int c0, hi, per;
  // clock, cycle count, ready loop-back
  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  always_comb begin
    bus = m;
    bus.hready = hreadyout;
  end
  tmw_pins pins (.clock(clock), .capture_in_a(cia), .capture_in_b(cib), .ext_clock_in(eck));
  tmw_timer dut (.clock(clock), .rst(rst), .ahb_in(bus), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_in_a(cia), .capture_in_b(cib), .ext_clock_in(eck), .compare_out_a(oa),
    .compare_out_b(ob), .irq(irq));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bounded wait for ready at a rising edge
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (hreadyout !== 1'b1 && k < 40);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_rdy
  // single word transfer, read data left in rd
  task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    m.sel <= 1'b1;
    m.htrans <= tmw_pkg::tmw_htrans_nonseq;
    m.haddr <= {24'h000000, a};
    m.hwrite <= w;
    m.hsize <= tmw_pkg::tmw_hsize_word;
    wait_rdy();
    m.sel <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= {16'h0000, d};
    wait_rdy();
    rd = hrdata[15:0];
  endtask : op
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic till_a(input logic v);
    int k;
    k = 0;
    while (oa !== v && k < 200) begin
      settle(1);
      k++;
    end
    if (oa !== v) begin
      n_fail++;
      wrap_up();
    end
  endtask : till_a
  // high time and period of output a in clocks
  task automatic meas;
    till_a(1'b0);
    till_a(1'b1);
    c0 = cyc;
    till_a(1'b0);
    hi = cyc - c0;
    till_a(1'b1);
    per = cyc - c0;
  endtask : meas
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    op(0, 8'h08, 16'h0000);
    chk("compare a reset", 16'h8000, rd);
    op(0, 8'h20, 16'h0000);
    chk("unmapped read", 16'h0000, rd);
    op(0, 8'h00, 16'h0000);
    sv = rd;
    op(1, 8'h00, 16'h1234);
    op(0, 8'h00, 16'h0000);
    chk("capture a read only", sv, rd);
    // forced levels, captures still work
    op(1, 8'h18, 16'hF800);
    op(1, 8'h14, 16'h0FCC);
    settle(2);
    chk("forced a", 1'b1, oa);
    chk("forced b", 1'b1, ob);
    op(1, 8'h14, 16'h0ECC);
    settle(2);
    chk("forced a low", 1'b0, oa);
    chk("irq while forced", 1'b0, irq);
    pins.pulse(0, 2, 2);
    pins.pulse(1, 2, 2);
    op(0, 8'h1C, 16'h0000);
    chk("capture flags", 16'h9000, rd);
    op(0, 8'h00, 16'h0000);
    chk("capture a count", 16'hFFFC, rd);
    // single pulse with both mode bits and force a, retriggered
    op(1, 8'h08, 16'h0020);
    op(1, 8'h0C, 16'h0010);
    op(1, 8'h14, 16'h8674);
    op(1, 8'h1C, 16'h0000);
    c0 = cyc;
    pins.pulse(0, 8, 8);
    pins.pulse(0, 8, 8);
    till_a(1'b0);
    chk("pulse length", 1'b1, (cyc - c0) >= 52 && (cyc - c0) <= 58);
    op(0, 8'h1C, 16'h0000);
    chk("single flags", 16'hA800, rd);
    op(0, 8'h00, 16'h0000);
    chk("trigger capture", 16'hFFFC, rd);
    op(1, 8'h10, 16'h0000);
    op(0, 8'h10, 16'h0000);
    chk("late write keeps count", 1'b1, rd >= 16'h0020 && rd < 16'hFF00);
    settle(45);
    chk("late count write", 1'b0, oa);
    // pwm with forced b
    op(1, 8'h08, 16'h0008);
    op(1, 8'h18, 16'h0800);
    op(1, 8'h14, 16'h8AD0);
    // restart the counter so the period starts at once
    op(1, 8'h10, 16'h0000);
    op(1, 8'h1C, 16'h0000);
    meas();
    chk("pwm high", 16'd13, hi[15:0]);
    chk("pwm period", 16'd21, per[15:0]);
    chk("pwm forced b", 1'b1, ob);
    op(0, 8'h1C, 16'h0000);
    chk("pwm flags", 16'h2800, rd);
    chk("pwm irq", 1'b1, irq);
    op(1, 8'h18, 16'h4000);
    settle(30);
    chk("pwm flag a irq", 1'b0, irq);
    op(1, 8'h08, 16'h0010);
    meas();
    chk("equal high", 16'd21, hi[15:0]);
    chk("equal period", 16'd42, per[15:0]);
    op(1, 8'h08, 16'hFFFC);
    op(1, 8'h0C, 16'hFFFC);
    op(1, 8'h10, 16'h0000);
    meas();
    chk("stuck high", 16'd1, hi[15:0]);
    chk("stuck period", 16'd2, per[15:0]);
    op(0, 8'h10, 16'h0000);
    chk("stuck count", 16'hFFFC, rd);
    // park output a low, then an unordered compare pair
    op(1, 8'h14, 16'h8440);
    op(1, 8'h08, 16'h0020);
    op(1, 8'h0C, 16'h0010);
    op(1, 8'h14, 16'h8AD0);
    op(1, 8'h10, 16'h0000);
    settle(30);
    chk("idle level", 1'b0, oa);
    sv = {15'h0000, oa};
    hi = 0;
    repeat (60) begin
      settle(1);
      if (oa !== sv[0]) hi++;
    end
    chk("no waveform", 16'd0, hi[15:0]);
    // width measurement, edge b inverse of edge a
    op(1, 8'h14, 16'hC004);
    op(1, 8'h1C, 16'h0000);
    op(1, 8'h18, 16'h8000);
    pins.pulse(0, 10, 20);
    chk("first capture irq", 1'b0, irq);
    pins.pulse(0, 10, 20);
    chk("second capture irq", 1'b1, irq);
    op(0, 8'h00, 16'h0000);
    chk("period", 1'b1, rd >= 16'd29 && rd <= 16'd31);
    op(0, 8'h04, 16'h0000);
    chk("width", 1'b1, rd >= 16'd9 && rd <= 16'd11);
    // external clock path: one tick per rising edge of a quarter-rate pin
    op(1, 8'h14, 16'h8003);
    op(1, 8'h10, 16'h0000);
    settle(40);
    op(0, 8'h10, 16'h0000);
    chk("external ticks", 1'b1, rd >= 16'h0004 && rd <= 16'h0009);
    wrap_up();
  end
endmodule : tb_top
